// [hdl/fmspd_ctl.v]
// Command control for quad mode, suspend/resume, function register and power-down
`timescale 1ns/1ps
`include "fmspd_defines.vh"

module fmspd_ctl #(
    parameter SUS_READY_CYC = `FMSPD_SUS_READY_US * `FMSPD_CLK_MHZ,
    parameter PD_ENTRY_CYC  = `FMSPD_PD_ENTRY_US * `FMSPD_CLK_MHZ,
    parameter TRES_CYC      = `FMSPD_TRES_US * `FMSPD_CLK_MHZ
) (
    input  wire       clk,
    input  wire       resetn,
    input  wire       ce_n,
    input  wire       sck,
    input  wire [3:0] io_in,
    input  wire       op_done,
    output reg        quad_command_mode,
    output reg        write_enable_latch,
    output reg        write_in_progress,
    output reg        program_suspended_flag,
    output reg        erase_suspended_flag,
    output reg        boot_area_select,
    output reg  [3:0] info_row_lock_bits,
    output reg        powered_down,
    output reg        op_run,
    output reg  [1:0] op_kind,
    output reg        op_start,
    output reg        cmd_valid,
    output reg  [7:0] cmd_code
);

    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_BUSY  = 7'h02;
    localparam [6:0] ST_SUSW  = 7'h04;
    localparam [6:0] ST_SUSP  = 7'h08;
    localparam [6:0] ST_DPENT = 7'h10;
    localparam [6:0] ST_DPD   = 7'h20;
    localparam [6:0] ST_DPREL = 7'h40;

    // Full-width counts, cut to the timer width on purpose
    localparam [31:0] SUS_FULL = SUS_READY_CYC - 1;
    localparam [31:0] PD_FULL  = PD_ENTRY_CYC - 1;
    localparam [31:0] REL_FULL = TRES_CYC - 1;
    localparam [14:0] SUS_LOAD = SUS_FULL[14:0];
    localparam [14:0] PD_LOAD  = PD_FULL[14:0];
    localparam [14:0] REL_LOAD = REL_FULL[14:0];

    function fmspd_is_prog;
        input [7:0] c;
        begin
            fmspd_is_prog = (c == `FMSPD_OP_PP) || (c == `FMSPD_OP_PPQ_A)
                         || (c == `FMSPD_OP_PPQ_B);
        end
    endfunction

    function fmspd_is_erase;
        input [7:0] c;
        begin
            fmspd_is_erase = (c == `FMSPD_OP_SER_A) || (c == `FMSPD_OP_SER_B)
                          || (c == `FMSPD_OP_BER32) || (c == `FMSPD_OP_BER64);
        end
    endfunction

    function fmspd_is_chip;
        input [7:0] c;
        begin
            fmspd_is_chip = (c == `FMSPD_OP_CER_A) || (c == `FMSPD_OP_CER_B);
        end
    endfunction

    // Opcodes allowed while suspended
    function fmspd_susp_ok;
        input [7:0] c;
        begin
            case (c)
                8'h03, 8'h0B, 8'hBB, 8'h3B, 8'hEB, 8'h6B, 8'h0D, 8'hBD, 8'hED,
                8'h05, 8'h48, 8'h7A, 8'h30, 8'hAB, 8'hC0, 8'h9F, 8'h90, 8'hAF,
                8'h4B, 8'h5A, 8'h00, 8'h66, 8'h99, 8'h68:
                    fmspd_susp_ok = 1'b1;
                default:
                    fmspd_susp_ok = 1'b0;
            endcase
        end
    endfunction

    reg  [5:0]  pin_s1_reg;
    reg  [5:0]  pin_s2_reg;
    reg         sck_d_reg;
    reg         ce_d_reg;
    reg  [7:0]  shift_reg;
    reg  [4:0]  bitcnt_reg;
    reg  [7:0]  cmd_reg;
    reg  [7:0]  data_reg;
    reg  [6:0]  state_reg;
    reg  [14:0] timer_reg;
    reg         rst_arm_reg;

    wire        ce_s     = pin_s2_reg[5];
    wire        sck_s    = pin_s2_reg[4];
    wire [3:0]  io_s     = pin_s2_reg[3:0];
    wire        sck_rise = sck_s & ~sck_d_reg & ~ce_s;
    wire        ce_rise  = ce_s & ~ce_d_reg;
    wire        got_cmd  = ce_rise && (bitcnt_reg >= `FMSPD_BITS_CMD);
    wire        exact1   = (bitcnt_reg == `FMSPD_BITS_CMD);
    wire        is_sus   = (cmd_reg == `FMSPD_OP_SUS_A) || (cmd_reg == `FMSPD_OP_SUS_B);
    wire        is_rsm   = (cmd_reg == `FMSPD_OP_RSM_A) || (cmd_reg == `FMSPD_OP_RSM_B);
    wire        timer_z  = (timer_reg == 15'h0000);
    wire [7:0]  shift_next;
    wire [4:0]  bitcnt_next;

    // Quad mode shifts a nibble per clock, high nibble first
    assign shift_next  = quad_command_mode ? {shift_reg[3:0], io_s}
                                           : {shift_reg[6:0], io_s[0]};
    assign bitcnt_next = quad_command_mode ? bitcnt_reg + 5'h04 : bitcnt_reg + 5'h01;

    // Pins cross from the host's clock domain
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_s1_reg <= 6'h20;
            pin_s2_reg <= 6'h20;
            sck_d_reg  <= 1'b0;
            ce_d_reg   <= 1'b1;
        end
        else
        begin
            pin_s1_reg <= {ce_n, sck, io_in};
            pin_s2_reg <= pin_s1_reg;
            sck_d_reg  <= sck_s;
            ce_d_reg   <= ce_s;
        end
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_reg  <= 8'h00;
            bitcnt_reg <= 5'h00;
            cmd_reg    <= 8'h00;
            data_reg   <= 8'h00;
        end
        else if (ce_s)
        begin
            bitcnt_reg <= 5'h00;
        end
        else if (sck_rise && (bitcnt_reg < `FMSPD_BITS_DATA + 5'h04))
        begin
            shift_reg  <= shift_next;
            bitcnt_reg <= bitcnt_next;
            if (bitcnt_next == `FMSPD_BITS_CMD)
                cmd_reg <= shift_next;
            if (bitcnt_next == `FMSPD_BITS_DATA)
                data_reg <= shift_next;
        end
    end

    // Main command state machine; commands are decided at chip select rise, op_done and timer expiry in any cycle
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg              <= ST_IDLE;
            timer_reg              <= 15'h0000;
            rst_arm_reg            <= 1'b0;
            quad_command_mode      <= 1'b0;
            write_enable_latch     <= 1'b0;
            write_in_progress      <= 1'b0;
            program_suspended_flag <= 1'b0;
            erase_suspended_flag   <= 1'b0;
            boot_area_select       <= 1'b0;
            info_row_lock_bits     <= 4'h0;
            powered_down           <= 1'b0;
            op_run                 <= 1'b0;
            op_kind                <= 2'h0;
            op_start               <= 1'b0;
            cmd_valid              <= 1'b0;
            cmd_code               <= 8'h00;
        end
        else
        begin
            op_start  <= 1'b0;
            cmd_valid <= 1'b0;
            if (!timer_z)
                timer_reg <= timer_reg - 15'h0001;
            // Reset-enable is armed only by the command just before
            if (got_cmd && (state_reg != ST_DPD) && (state_reg != ST_SUSW))
                rst_arm_reg <= (cmd_reg == `FMSPD_OP_RST_EN);
            case (state_reg)
                ST_IDLE:
                begin
                    if (got_cmd)
                    begin
                        cmd_valid <= 1'b1;
                        cmd_code  <= cmd_reg;
                        if (cmd_reg == `FMSPD_OP_WR_EN)
                            write_enable_latch <= 1'b1;
                        else if (cmd_reg == `FMSPD_OP_WRDI)
                            write_enable_latch <= 1'b0;
                        else if (cmd_reg == `FMSPD_OP_RST && rst_arm_reg)
                        begin
                            write_enable_latch <= 1'b0;
                            quad_command_mode  <= 1'b0;
                        end
                        else if (cmd_reg == `FMSPD_OP_QEN && !quad_command_mode)
                            quad_command_mode <= 1'b1;
                        else if (cmd_reg == `FMSPD_OP_QDI && quad_command_mode && exact1)
                            quad_command_mode <= 1'b0;
                        else if (cmd_reg == `FMSPD_OP_FR_WRITE && write_enable_latch
                                 && bitcnt_reg >= `FMSPD_BITS_DATA)
                        begin
                            // OR-in only: bits can never return to zero
                            boot_area_select   <= boot_area_select
                                                | data_reg[`FMSPD_FR_BOOT];
                            info_row_lock_bits <= info_row_lock_bits
                                | data_reg[`FMSPD_FR_IRL_HI:`FMSPD_FR_IRL_LO];
                            write_enable_latch <= 1'b0;
                        end
                        else if (write_enable_latch && (fmspd_is_prog(cmd_reg)
                                 || fmspd_is_erase(cmd_reg) || fmspd_is_chip(cmd_reg)))
                        begin
                            state_reg         <= ST_BUSY;
                            op_run            <= 1'b1;
                            op_start          <= 1'b1;
                            write_in_progress <= 1'b1;
                            op_kind <= fmspd_is_prog(cmd_reg) ? `FMSPD_KIND_PROG
                                     : fmspd_is_erase(cmd_reg) ? `FMSPD_KIND_ERASE
                                     : `FMSPD_KIND_CHIP;
                        end
                        else if (cmd_reg == `FMSPD_OP_DPD)
                        begin
                            state_reg <= ST_DPENT;
                            timer_reg <= PD_LOAD;
                        end
                    end
                end
                ST_BUSY:
                begin
                    // Completion wins over a suspend in the same cycle
                    if (op_done)
                    begin
                        state_reg          <= ST_IDLE;
                        op_run             <= 1'b0;
                        write_in_progress  <= 1'b0;
                        write_enable_latch <= 1'b0;
                    end
                    else if (got_cmd && is_sus && op_kind != `FMSPD_KIND_CHIP)
                    begin
                        state_reg          <= ST_SUSW;
                        timer_reg          <= SUS_LOAD;
                        op_run             <= 1'b0;
                        write_enable_latch <= 1'b0;
                        program_suspended_flag <= (op_kind == `FMSPD_KIND_PROG);
                        erase_suspended_flag   <= (op_kind == `FMSPD_KIND_ERASE);
                    end
                    // Release is not listed here, so it is dropped while busy
                    else if (got_cmd && (cmd_reg == `FMSPD_OP_SR_READ
                             || cmd_reg == `FMSPD_OP_FR_READ))
                    begin
                        cmd_valid <= 1'b1;
                        cmd_code  <= cmd_reg;
                    end
                end
                ST_SUSW:
                begin
                    // Commands dropped until the array has parked
                    if (timer_z)
                    begin
                        state_reg         <= ST_SUSP;
                        write_in_progress <= 1'b0;
                    end
                end
                ST_SUSP:
                begin
                    if (got_cmd && fmspd_susp_ok(cmd_reg))
                    begin
                        cmd_valid <= 1'b1;
                        cmd_code  <= cmd_reg;
                        if (is_rsm)
                        begin
                            state_reg              <= ST_BUSY;
                            op_run                 <= 1'b1;
                            write_in_progress      <= 1'b1;
                            program_suspended_flag <= 1'b0;
                            erase_suspended_flag   <= 1'b0;
                        end
                        else if (cmd_reg == `FMSPD_OP_RST && rst_arm_reg)
                        begin
                            // Abandons the parked operation
                            state_reg              <= ST_IDLE;
                            quad_command_mode      <= 1'b0;
                            program_suspended_flag <= 1'b0;
                            erase_suspended_flag   <= 1'b0;
                        end
                    end
                end
                ST_DPENT:
                begin
                    if (timer_z)
                    begin
                        state_reg    <= ST_DPD;
                        powered_down <= 1'b1;
                    end
                end
                ST_DPD:
                begin
                    if (got_cmd && cmd_reg == `FMSPD_OP_REL)
                    begin
                        cmd_valid <= 1'b1;
                        cmd_code  <= cmd_reg;
                        state_reg <= ST_DPREL;
                        timer_reg <= REL_LOAD;
                    end
                end
                ST_DPREL:
                begin
                    // Chip select is expected high throughout
                    if (timer_z)
                    begin
                        state_reg    <= ST_IDLE;
                        powered_down <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // fmspd_ctl

// [hdl/fmspd_defines.vh]
// Constants for the flash mode, suspend and power-down control block
//
// Behaviour
// - Function-register write with boot select one moves protection to the bottom.
// - Each of four info-row lock bits settable independently by function-register write.
// - Boot select and row-lock bits are one-time: once one, never return to zero.
// - After enter-quad completes, all later commands come in on four lines.
// - Exit-quad, framed by chip select low and high, returns to single-line mode.
// - Exit-quad recognised only as a four-line command of exactly two clocks.
// - Both suspend and both resume opcodes work in either mode, on program or erase.
// - Function-register bit 2 shows program suspended, bit 3 shows erase suspended.
// - After a suspend no command is accepted until ready, at most 100 us.
// - Suspend during whole-chip erase is ignored; chip erase continues.
// - Successful suspend sets its flag and clears the write-enable latch together.
// - Resume restarts the suspended operation and clears the suspend flag.
// - In four-line mode each command byte is two nibbles, high nibble first.
// - While suspended only reads, resume, ID, parameter, no-op and reset pair accepted.
// - Software reset acts only directly after reset-enable, also while suspended.
// - Power-down enters only if chip select rises after full opcode, within entry time.
// - In deep power-down every command except release is ignored.
// - After release and chip select high, normal operation returns after release time.
// - Release received while an operation is in progress is ignored.
// - Function-register write needs the write-enable latch; latch clears when write ends.
// - Write-in-progress reads one while program or erase runs, zero when done.
`ifndef FMSPD_DEFINES_VH
`define FMSPD_DEFINES_VH

`define FMSPD_CLK_MHZ        200
`define FMSPD_SUS_READY_US   100
`define FMSPD_PD_ENTRY_US    3
`define FMSPD_TRES_US        3

`define FMSPD_OP_SR_WRITE    8'h01
`define FMSPD_OP_PP          8'h02
`define FMSPD_OP_NORD        8'h03
`define FMSPD_OP_WRDI        8'h04
`define FMSPD_OP_SR_READ     8'h05
`define FMSPD_OP_WR_EN       8'h06
`define FMSPD_OP_SER_A       8'h20
`define FMSPD_OP_SER_B       8'hD7
`define FMSPD_OP_BER32       8'h52
`define FMSPD_OP_BER64       8'hD8
`define FMSPD_OP_CER_A       8'hC7
`define FMSPD_OP_CER_B       8'h60
`define FMSPD_OP_PPQ_A       8'h32
`define FMSPD_OP_PPQ_B       8'h38
`define FMSPD_OP_FR_WRITE    8'h42
`define FMSPD_OP_FR_READ     8'h48
`define FMSPD_OP_QEN         8'h35
`define FMSPD_OP_QDI         8'hF5
`define FMSPD_OP_SUS_A       8'h75
`define FMSPD_OP_SUS_B       8'hB0
`define FMSPD_OP_RSM_A       8'h7A
`define FMSPD_OP_RSM_B       8'h30
`define FMSPD_OP_DPD         8'hB9
`define FMSPD_OP_REL         8'hAB
`define FMSPD_OP_RST_EN      8'h66
`define FMSPD_OP_RST         8'h99

`define FMSPD_FR_BOOT        1
`define FMSPD_FR_PROG_SUS    2
`define FMSPD_FR_ERASE_SUS   3
`define FMSPD_FR_IRL_LO      4
`define FMSPD_FR_IRL_HI      7

`define FMSPD_KIND_PROG      2'h1
`define FMSPD_KIND_ERASE     2'h2
`define FMSPD_KIND_CHIP      2'h3

`define FMSPD_BITS_CMD       5'h08
`define FMSPD_BITS_DATA      5'h10

`endif

// [verification/fmspd_host.sv]
// Host serial controller model: chip select, serial clock and data pins
`timescale 1ns/1ps
module fmspd_host (
    output logic       ce_n,
    output logic       sck,
    output logic [3:0] io
);
    initial
    begin
        ce_n = 1'b1;
        sck = 1'b0;
        io = 4'hA;
    end
    // Clock stands low between frames; released lines flip so stale data never looks valid
    task automatic xfer(input logic [15:0] d, input int nbits, input logic quad);
        int i;
        begin
            ce_n = 1'b0;
            for (i = 0; i < nbits; i = i + (quad ? 4 : 1))
            begin
                io = quad ? d[15 - i -: 4] : {~io[3:1], d[15 - i]};
                #62.5 sck = 1'b1;
                #62.5 sck = 1'b0;
            end
            #62.5 ce_n = 1'b1;
            io = ~io;
            #60;
        end
    endtask
endmodule // fmspd_host

// [verification/fmspd_ctl_chk.sv]
// Port assertions for the mode, suspend and power-down control
`timescale 1ns/1ps
module fmspd_ctl_chk #(
    parameter int SUS_READY_CYC = 20,
    parameter int PD_ENTRY_CYC  = 10,
    parameter int TRES_CYC = 10
) (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       op_done,
    input wire logic       quad_command_mode,
    input wire logic       write_enable_latch,
    input wire logic       write_in_progress,
    input wire logic       program_suspended_flag,
    input wire logic       erase_suspended_flag,
    input wire logic       boot_area_select,
    input wire logic [3:0] info_row_lock_bits,
    input wire logic       powered_down,
    input wire logic       op_run,
    input wire logic       op_start,
    input wire logic [1:0] op_kind,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_code
);
    localparam int SUS_LIM  = SUS_READY_CYC + 2;
    localparam int PD_LIM   = PD_ENTRY_CYC + 3;
    localparam int TRES_LIM = TRES_CYC + 3;
    wire [1:0] sus_flags = {program_suspended_flag, erase_suspended_flag};
    wire       resume_seen = cmd_valid && (cmd_code == 8'h7A || cmd_code == 8'h30);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_settle;
        write_in_progress ##[1:SUS_LIM] !write_in_progress;
    endsequence
    sequence s_release;
        powered_down [*8] ##[1:TRES_LIM] !powered_down;
    endsequence
    a_otp_sticky: assert property (
        ((info_row_lock_bits & $past(info_row_lock_bits)) == $past(info_row_lock_bits))
        && (boot_area_select || !$past(boot_area_select))) else $error("otp bit cleared");
    a_fr_needs_we: assert property (
        $changed({boot_area_select, info_row_lock_bits})
        |-> $past(write_enable_latch) && !write_enable_latch)
        else $error("function write without write enable");
    a_suspend_we_clr: assert property (
        $rose(|sus_flags) |-> !write_enable_latch && $fell(op_run))
        else $error("suspend left write enable set");
    a_suspend_ready: assert property (
        $rose(|sus_flags) |-> s_settle) else $error("suspend settle time");
    a_settle_refuse: assert property (
        write_in_progress && $past(|sus_flags) && (|sus_flags) |-> !cmd_valid)
        else $error("command taken while settling");
    a_flag_kind: assert property (
        $rose(|sus_flags) |-> sus_flags == (($past(op_kind) == 2'h1) ? 2'h2 : 2'h1))
        else $error("wrong suspend flag");
    a_chip_runs: assert property (
        op_run && op_kind == 2'h3 && !op_done |=> op_run && sus_flags == 2'h0)
        else $error("chip erase suspended");
    a_resume_clears: assert property (
        resume_seen && $past(|sus_flags) |-> sus_flags == 2'h0 && op_run && write_in_progress)
        else $error("resume failed");
    a_pd_ignore: assert property (
        powered_down && cmd_valid |-> cmd_code == 8'hAB) else $error("command in power-down");
    a_pd_entry: assert property (
        cmd_valid && cmd_code == 8'hB9 && !powered_down |-> ##[1:PD_LIM] powered_down)
        else $error("power-down entry late");
    a_pd_release: assert property (
        cmd_valid && cmd_code == 8'hAB && powered_down |-> s_release) else $error("release");
    a_quad_enter: assert property (
        $rose(quad_command_mode) |-> cmd_valid && cmd_code == 8'h35) else $error("quad entry");
    a_quad_exit: assert property (
        $fell(quad_command_mode) |-> cmd_valid && (cmd_code == 8'hF5 || cmd_code == 8'h99))
        else $error("quad exit");
    a_wip_done: assert property (
        op_run && op_done |=> !op_run && !write_in_progress) else $error("busy after done");
    a_start_pulse: assert property (
        (op_start || $rose(op_run)) |-> op_start == ($rose(op_run) && !$past(|sus_flags)))
        else $error("op start pulse wrong");
endmodule // fmspd_ctl_chk

bind fmspd_ctl fmspd_ctl_chk #(.SUS_READY_CYC(SUS_READY_CYC), .PD_ENTRY_CYC(PD_ENTRY_CYC),
    .TRES_CYC(TRES_CYC))
    fmspd_ctl_chk_inst (.clk(clk), .resetn(resetn), .op_done(op_done),
    .quad_command_mode(quad_command_mode), .write_enable_latch(write_enable_latch),
    .write_in_progress(write_in_progress), .program_suspended_flag(program_suspended_flag),
    .erase_suspended_flag(erase_suspended_flag), .boot_area_select(boot_area_select),
    .info_row_lock_bits(info_row_lock_bits), .powered_down(powered_down), .op_run(op_run),
    .op_kind(op_kind), .op_start(op_start), .cmd_valid(cmd_valid), .cmd_code(cmd_code));

// [verification/fmspd_ctl_test.sv]
// Self-checking bench for the mode, suspend and power-down control
`timescale 1ns/1ps
module fmspd_ctl_test;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       op_done = 1'b0;
    wire        ce_n, sck, qm, we_lat, in_prog, prog_sus, erase_sus, bas, pd, run;
    wire  [3:0] io, irl;
    wire  [1:0] kind;
    wire  [7:0] st = {pd, qm, we_lat, in_prog, prog_sus, erase_sus, run, bas};
    int         miscompares = 0;
    int         compares = 0;
    always #2.5 clk = ~clk;
    fmspd_host fmspd_host_inst (.ce_n(ce_n), .sck(sck), .io(io));
    // Long settle so a command can land inside it
    fmspd_ctl #(.SUS_READY_CYC(400), .PD_ENTRY_CYC(10), .TRES_CYC(10)) fmspd_ctl_inst (
        .clk(clk), .resetn(resetn), .ce_n(ce_n), .sck(sck), .io_in(io), .op_done(op_done),
        .quad_command_mode(qm), .write_enable_latch(we_lat), .write_in_progress(in_prog),
        .program_suspended_flag(prog_sus), .erase_suspended_flag(erase_sus),
        .boot_area_select(bas),
        .info_row_lock_bits(irl), .powered_down(pd), .op_run(run), .op_kind(kind),
        .op_start(), .cmd_valid(), .cmd_code());
    task automatic print_verdict;
        begin
            $display("compares %0d miscompares %0d", compares, miscompares);
            if (miscompares == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        begin
            compares++;
            if (seen !== exp)
            begin
                miscompares++;
                $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] dat = 8'h00, input int n = 8);
        begin
            @(posedge clk);
            #1 fmspd_host_inst.xfer({op, dat}, n, qm === 1'b1);
        end
    endtask
    task automatic pulse_done;
        begin
            @(posedge clk);
            #1 op_done = 1'b1;
            @(posedge clk);
            #1 op_done = 1'b0;
            @(posedge clk);
            #1;
        end
    endtask
    // No second suspend after a resume, so the resume-to-suspend wait holds
    task automatic susp(input logic [7:0] op, sus, rsm, fl, input logic [1:0] k);
        logic [7:0] b;
        int         i;
        begin
            b = {1'b0, qm, 6'h01};
            cmd(8'h06);
            cmd(op);
            chk(st, b | 8'h32);
            chk({6'h00, kind}, {6'h00, k});
            cmd(sus);
            chk(st, b | 8'h10 | fl);
            cmd(8'h06);
            chk(st, b | 8'h10 | fl);
            for (i = 0; i < 1000 && in_prog !== 1'b0; i++)
                @(posedge clk);
            #1 chk(st, b | fl);
            cmd(8'h06); // Harmless while suspended
            chk(st, b | fl);
            cmd(rsm);
            chk(st, b | 8'h12);
            pulse_done();
            chk(st, b);
        end
    endtask
    initial
    begin
        #300000;
        miscompares++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        #1 resetn = 1'b1;
        chk(st, 8'h00);
        chk({4'h0, irl}, 8'h00);
        cmd(8'h42, 8'h12, 16);
        chk({3'h0, irl, bas}, 8'h00);
        cmd(8'h06);
        chk(st, 8'h20);
        cmd(8'h42, 8'h12, 16);
        chk({3'h0, irl, bas}, 8'h03);
        chk(st, 8'h01);
        cmd(8'h06);
        cmd(8'h42, 8'h80, 16);
        chk({3'h0, irl, bas}, 8'h13);
        cmd(8'h06);
        cmd(8'h42, 8'h00, 16);
        chk({3'h0, irl, bas}, 8'h13);
        $display("test function register done");
        susp(8'h02, 8'h75, 8'h7A, 8'h08, 2'h1);
        cmd(8'h35);
        chk(st, 8'h41);
        susp(8'hD8, 8'hB0, 8'h30, 8'h04, 2'h2);
        cmd(8'hF5, 8'h00, 16);
        chk(st, 8'h41);
        cmd(8'hF5);
        chk(st, 8'h01);
        $display("test suspend and quad done");
        cmd(8'h06);
        cmd(8'hC7);
        cmd(8'h75);
        chk(st, 8'h33);
        chk({6'h00, kind}, 8'h03);
        pulse_done();
        cmd(8'h06);
        cmd(8'h02);
        cmd(8'hAB);
        chk(st, 8'h33);
        pulse_done();
        cmd(8'h06);
        cmd(8'h99);
        chk(st, 8'h21);
        cmd(8'h66);
        cmd(8'h99);
        chk(st, 8'h01);
        cmd(8'h06);
        cmd(8'h02);
        cmd(8'h75);
        repeat (500) @(posedge clk);
        #1 chk(st, 8'h09);
        cmd(8'h66);
        cmd(8'h99);
        chk(st, 8'h01);
        $display("test chip erase and reset done");
        cmd(8'hB9, 8'h00, 7);
        repeat (20) @(posedge clk);
        chk(st, 8'h01);
        cmd(8'hB9);
        repeat (20) @(posedge clk);
        chk(st, 8'h81);
        cmd(8'h06);
        chk(st, 8'h81);
        cmd(8'hAB);
        repeat (20) @(posedge clk); // Chip select held high throughout
        chk(st, 8'h01);
        $display("test power-down done");
        print_verdict();
    end
endmodule // fmspd_ctl_test
